// ---- pfc_pkg.sv ----
package pfc_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS         = 40;
	localparam int RC_NS          = 100;
	localparam int WP_NS          = 50;
	localparam int WPH_NS         = 30;
	localparam int RP_NS          = 500;
	localparam int RH_NS          = 50;
	localparam int READY_ALGO_NS  = 20000;
	localparam int POLL_WAIT_NS   = 4000;
	localparam int BYTE_Z_NS      = 25;
	localparam int RC_CYC         = (RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC         = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC        = (WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC         = (RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC         = (RH_NS + CLK_NS - 1) / CLK_NS;
	localparam int READY_CYC      = (READY_ALGO_NS + CLK_NS - 1) / CLK_NS;
	localparam int POLL_CYC       = (POLL_WAIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int BYTE_Z_CYC     = (BYTE_Z_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W          = 10;
	localparam int DQ_W           = 16;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_RDATA  = 8'h14;
	localparam int CTRL_BYTE   = 0;
	localparam int STS_BUSY    = 0;
	localparam int STS_POLL_OK = 1;
	localparam int STS_WAITED  = 2;
	localparam int STS_SUSP    = 3;
	localparam int STS_RDY_PIN = 4;
	localparam int STS_REWAIT  = 5;
	localparam int TOGGLE_BIT  = 6;
	localparam logic       CTRL_BYTE_RST = 1'b0;
	localparam logic [3:0] ENG_CNT_RST   = 4'h0;

	typedef enum logic [2:0] {
		OP_READ    = 3'b000,
		OP_WRITE   = 3'b001,
		OP_PROG    = 3'b010,
		OP_SUSPEND = 3'b011,
		OP_RESUME  = 3'b100,
		OP_POLL    = 3'b101,
		OP_RESET   = 3'b110,
		OP_NONE    = 3'b111
	} pfc_op_type;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_DISPATCH  = 3'b001,
		ST_CYCLE     = 3'b010,
		ST_RST_LOW   = 3'b011,
		ST_RST_WAIT  = 3'b100,
		ST_POLL_GATE = 3'b101,
		ST_POLL_RD   = 3'b110,
		ST_POLL_CHK  = 3'b111
	} pfc_state_type;

	typedef enum logic [1:0] {
		E_IDLE    = 2'b00,
		E_STROBE  = 2'b01,
		E_RECOVER = 2'b10
	} pfc_eng_type;
endpackage

module pfc_bus_cycle #(
	parameter int ADDR_W = 21
) (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [pfc_pkg::DQ_W-1:0] wdata,
	input  wire logic              byte_mode,
	input  wire logic [pfc_pkg::DQ_W-1:0] dq_in,
	output logic                   ce_n,
	output logic                   oe_n,
	output logic                   we_n,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [pfc_pkg::DQ_W-1:0] dq_out,
	output logic                   dq_oe_n,
	output logic [pfc_pkg::DQ_W-1:0] rdata,
	output logic                   done
);
	import pfc_pkg::*;

	pfc_eng_type estate;
	logic [3:0]  cnt;
	logic        wr;

	// ----------------------------------------
	// One bus cycle: strobe then recovery
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			estate  <= E_IDLE;
			cnt     <= ENG_CNT_RST;
			wr      <= 1'b0;
			ce_n    <= 1'b1;
			oe_n    <= 1'b1;
			we_n    <= 1'b1;
			addr_o  <= '0;
			dq_out  <= '0;
			dq_oe_n <= 1'b1;
			rdata   <= '0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			case (estate)
				E_IDLE: begin
					if (start) begin
						wr      <= is_write;
						ce_n    <= 1'b0;
						oe_n    <= is_write;
						we_n    <= !is_write;
						addr_o  <= addr;
						dq_out  <= byte_mode ? {8'h00, wdata[7:0]} : wdata;
						dq_oe_n <= !is_write;
						cnt     <= is_write ? 4'(WP_CYC - 1) : 4'(RC_CYC - 1);
						estate  <= E_STROBE;
					end
				end
				E_STROBE: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						if (!wr) begin
							rdata <= byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
						end
						// Both strobes rise so toggle bits advance
						ce_n   <= 1'b1;
						oe_n   <= 1'b1;
						we_n   <= 1'b1;
						cnt    <= 4'(WPH_CYC - 1);
						estate <= E_RECOVER;
					end
				end
				E_RECOVER: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else begin
						dq_oe_n <= 1'b1;
						done    <= 1'b1;
						estate  <= E_IDLE;
					end
				end
				default: begin
					estate <= E_IDLE;
				end
			endcase
		end
	end

	property p_read_strobe;
		@(posedge core_clk) disable iff (!resetn)
		$fell(oe_n) |-> !oe_n [*3] ##1 oe_n;
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("read strobe width wrong");

	property p_toggle_pulse;
		@(posedge core_clk) disable iff (!resetn)
		$fell(oe_n) |-> $past(ce_n) && $fell(ce_n);
	endproperty
	a_toggle_pulse: assert property (p_toggle_pulse) else $error("no select pulse before read");

	property p_write_pulse;
		@(posedge core_clk) disable iff (!resetn)
		$fell(we_n) |-> !we_n [*2] ##1 (we_n && !dq_oe_n);
	endproperty
	a_write_pulse: assert property (p_write_pulse) else $error("write pulse width wrong");
endmodule

// ---- pfc_flash_ctrl.sv ----
module pfc_flash_ctrl #(
	parameter int ADDR_W = 21
) (
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic [31:0]                   hrdata,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic                          flash_reset_n,
	output logic                          flash_ce_n,
	output logic                          flash_oe_n,
	output logic                          flash_we_n,
	output logic                          flash_byte_n,
	output logic [ADDR_W-1:0]             flash_addr,
	output logic [pfc_pkg::DQ_W-1:0]      flash_dq_out,
	output logic                          flash_dq_oe_n,
	input  wire logic [pfc_pkg::DQ_W-1:0] flash_dq_in,
	input  wire logic                     ready_busy_n
);
	import pfc_pkg::*;

	if (ADDR_W < 2 || ADDR_W > 30) begin : g_bad_addr
		$error("ADDR_W out of range");
	end

	pfc_state_type          state;
	pfc_op_type             op_reg;
	logic                   wr_pend;
	logic [7:0]             wr_ofs;
	logic                   byte_mode;
	logic [ADDR_W-1:0]      addr_reg;
	logic [DQ_W-1:0]        wdata_reg;
	logic [DQ_W-1:0]        rdata_reg;
	logic [DQ_W-1:0]        eng_rdata;
	logic                   eng_done;
	logic                   eng_start;
	logic                   eng_write;
	logic [1:0]             settle;
	logic [TMR_W-1:0]       tmr;
	logic [TMR_W-1:0]       wait_cnt;
	logic                   wait_elapsed;
	logic                   suspended;
	logic                   rewait;
	logic                   poll_ok;
	logic                   have_prev;
	logic                   prev_toggle;
	logic                   poll_equal;
	logic                   cmd_take;
	logic                   ctrl_take;
	logic [31:0]            status_word;
	logic [31:0]            next_hrdata;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign cmd_take  = wr_pend && wr_ofs == OFS_CMD && state == ST_IDLE;
	assign ctrl_take = wr_pend && wr_ofs == OFS_CTRL && state == ST_IDLE;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend <= 1'b0;
			wr_ofs  <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_ofs  <= haddr[7:0];
		end
	end

	always_comb begin
		status_word              = 32'h0000_0000;
		status_word[STS_BUSY]    = state != ST_IDLE;
		status_word[STS_POLL_OK] = poll_ok;
		status_word[STS_WAITED]  = wait_elapsed;
		status_word[STS_SUSP]    = suspended;
		status_word[STS_RDY_PIN] = ready_busy_n;
		status_word[STS_REWAIT]  = rewait;
		case (haddr[7:0])
			OFS_CTRL:   next_hrdata = {31'h0, byte_mode};
			OFS_ADDR:   next_hrdata = 32'(addr_reg);
			OFS_WDATA:  next_hrdata = {16'h0000, wdata_reg};
			OFS_CMD:    next_hrdata = {29'h0, op_reg};
			OFS_STATUS: next_hrdata = status_word;
			OFS_RDATA:  next_hrdata = {16'h0000, rdata_reg};
			default:    next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= next_hrdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addr_reg  <= '0;
			wdata_reg <= '0;
		end else if (wr_pend && wr_ofs == OFS_ADDR) begin
			addr_reg <= hwdata[ADDR_W-1:0];
		end else if (wr_pend && wr_ofs == OFS_WDATA) begin
			wdata_reg <= hwdata[DQ_W-1:0];
		end
	end

	// ----------------------------------------
	// Width select and settle time
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			byte_mode    <= CTRL_BYTE_RST;
			flash_byte_n <= !CTRL_BYTE_RST;
			settle       <= 2'b00;
		end else if (ctrl_take && hwdata[CTRL_BYTE] != byte_mode) begin
			byte_mode    <= hwdata[CTRL_BYTE];
			flash_byte_n <= !hwdata[CTRL_BYTE];
			settle       <= 2'(BYTE_Z_CYC);
		end else if (settle != 2'b00) begin
			settle <= settle - 2'b01;
		end
	end

	// ----------------------------------------
	// Main sequencer
	// ----------------------------------------
	assign poll_equal = have_prev && prev_toggle == eng_rdata[TOGGLE_BIT];
	assign eng_write  = state == ST_DISPATCH && op_reg != OP_READ && op_reg != OP_POLL;

	always_comb begin
		eng_start = 1'b0;
		case (state)
			ST_DISPATCH:  eng_start = settle == 2'b00 && op_reg != OP_POLL && op_reg != OP_RESET;
			ST_POLL_GATE: eng_start = wait_elapsed || suspended;
			ST_POLL_CHK:  eng_start = !ready_busy_n && !poll_equal;
			default:      eng_start = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state         <= ST_IDLE;
			op_reg        <= OP_NONE;
			tmr           <= '0;
			flash_reset_n <= 1'b1;
			rdata_reg     <= '0;
			poll_ok       <= 1'b0;
			have_prev     <= 1'b0;
			prev_toggle   <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (cmd_take) begin
						op_reg <= pfc_op_type'(hwdata[2:0]);
						state  <= ST_DISPATCH;
					end
				end
				ST_DISPATCH: begin
					if (settle == 2'b00) begin
						if (op_reg == OP_RESET) begin
							flash_reset_n <= 1'b0;
							tmr           <= TMR_W'(RP_CYC - 1);
							state         <= ST_RST_LOW;
						end else if (op_reg == OP_POLL) begin
							poll_ok   <= 1'b0;
							have_prev <= 1'b0;
							state     <= ST_POLL_GATE;
						end else begin
							state <= ST_CYCLE;
						end
					end
				end
				ST_CYCLE: begin
					if (eng_done) begin
						if (op_reg == OP_READ) begin
							rdata_reg <= eng_rdata;
						end
						state <= ST_IDLE;
					end
				end
				ST_RST_LOW: begin
					if (tmr != '0) begin
						tmr <= tmr - 1'b1;
					end else begin
						flash_reset_n <= 1'b1;
						tmr           <= TMR_W'(READY_CYC + RH_CYC - 1);
						state         <= ST_RST_WAIT;
					end
				end
				ST_RST_WAIT: begin
					if (tmr != '0) begin
						tmr <= tmr - 1'b1;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_POLL_GATE: begin
					if (eng_start) begin
						state <= ST_POLL_RD;
					end
				end
				ST_POLL_RD: begin
					if (eng_done) begin
						state <= ST_POLL_CHK;
					end
				end
				ST_POLL_CHK: begin
					rdata_reg <= eng_rdata;
					if (ready_busy_n || poll_equal) begin
						poll_ok <= 1'b1;
						state   <= ST_IDLE;
					end else begin
						prev_toggle <= eng_rdata[TOGGLE_BIT];
						have_prev   <= 1'b1;
						state       <= ST_POLL_RD;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status poll wait and suspend tracking
	// ----------------------------------------
	assign wait_elapsed = wait_cnt == '0;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wait_cnt  <= '0;
			suspended <= 1'b0;
			rewait    <= 1'b0;
		end else if (state == ST_RST_LOW) begin
			wait_cnt  <= '0;
			suspended <= 1'b0;
			rewait    <= 1'b0;
		end else if (state == ST_CYCLE && eng_done && op_reg == OP_PROG) begin
			wait_cnt  <= TMR_W'(POLL_CYC);
			suspended <= 1'b0;
			rewait    <= 1'b0;
		end else if (state == ST_CYCLE && eng_done && op_reg == OP_SUSPEND) begin
			suspended <= 1'b1;
			rewait    <= !wait_elapsed;
		end else if (state == ST_CYCLE && eng_done && op_reg == OP_RESUME) begin
			suspended <= 1'b0;
			rewait    <= 1'b0;
			wait_cnt  <= rewait ? TMR_W'(POLL_CYC) : '0;
		end else if (!suspended && !wait_elapsed) begin
			wait_cnt <= wait_cnt - 1'b1;
		end
	end

	pfc_bus_cycle #(
		.ADDR_W (ADDR_W)
	) u_cycle (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.start     (eng_start),
		.is_write  (eng_write),
		.addr      (addr_reg),
		.wdata     (wdata_reg),
		.byte_mode (byte_mode),
		.dq_in     (flash_dq_in),
		.ce_n      (flash_ce_n),
		.oe_n      (flash_oe_n),
		.we_n      (flash_we_n),
		.addr_o    (flash_addr),
		.dq_out    (flash_dq_out),
		.dq_oe_n   (flash_dq_oe_n),
		.rdata     (eng_rdata),
		.done      (eng_done)
	);

	property p_reset_recovery;
		@(posedge core_clk) disable iff (!resetn)
		$rose(flash_reset_n) |-> flash_oe_n [*8];
	endproperty
	a_reset_recovery: assert property (p_reset_recovery) else $error("read too soon after reset");

	property p_ready_done;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_POLL_CHK && ready_busy_n |=> state == ST_IDLE && poll_ok;
	endproperty
	a_ready_done: assert property (p_ready_done) else $error("ready not taken at once");

	property p_poll_gate;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_POLL_GATE && !suspended && wait_cnt != '0 |=> state == ST_POLL_GATE && flash_oe_n;
	endproperty
	a_poll_gate: assert property (p_poll_gate) else $error("status read before wait");

	property p_rewait;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_CYCLE && eng_done && op_reg == OP_RESUME && rewait |=> wait_cnt == TMR_W'(POLL_CYC) ##1 !wait_elapsed;
	endproperty
	a_rewait: assert property (p_rewait) else $error("wait not reapplied");

	property p_no_rewait;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_CYCLE && eng_done && op_reg == OP_RESUME && !rewait |=> wait_elapsed && !suspended;
	endproperty
	a_no_rewait: assert property (p_no_rewait) else $error("needless wait after resume");

	property p_toggle_done;
		@(posedge core_clk) disable iff (!resetn)
		state == ST_POLL_CHK && !ready_busy_n && !poll_equal |=> state == ST_POLL_RD && !poll_ok;
	endproperty
	a_toggle_done: assert property (p_toggle_done) else $error("poll ended while toggling");
endmodule

// ---- pfc_flash_model.sv ----
module pfc_flash_model #(
	parameter int          PROG_CYC  = 300,
	parameter int          POLL      = 100,
	parameter int          RH        = 2,
	parameter logic [15:0] PROG_CODE = 16'h00a0,
	parameter logic [15:0] SUSP_CODE = 16'h00b0,
	parameter logic [15:0] RES_CODE  = 16'h0030
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        byte_n,
	input  wire logic [20:0] addr,
	input  wire logic [15:0] din,
	output logic [15:0]      dq,
	output logic             ready_busy_n,
	output logic [7:0]       bad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:255];
	logic [15:0] pdata;
	logic [15:0] last;
	logic [15:0] val;
	logic        busy;
	logic        susp;
	logic        armed;
	logic        tog;
	logic        we_q;
	logic        rd_q;
	int          left;
	int          pw;
	int          rh;

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'ha500 ^ 16'(i);
		end
		{busy, susp, armed, tog, we_q, rd_q} = 6'h03;
		{pdata, last, bad} = '0;
		{left, pw, rh} = {32'd0, POLL, RH};
	end

	assign ready_busy_n = !(busy && !susp);
	// ----
	// Status while running, array data otherwise
	// ----
	always @* begin
		if (busy && !susp)
			val = {8'h00, ~pdata[7], tog, 6'h00};
		else
			val = mem[addr[7:0]];
		if (!byte_n)
			val[15:8] = ~last[15:8];
	end
	// Released bus keeps changing
	assign dq = (!ce_n && !oe_n) ? val : ~last;

	always @(posedge core_clk) begin
		we_q <= we_n;
		rd_q <= ce_n | oe_n;
		last <= dq;
		if (!reset_n) begin
			busy  <= 1'b0;
			susp  <= 1'b0;
			armed <= 1'b0;
			rh    <= 0;
		end else begin
			if (rh < RH)
				rh <= rh + 1;
			if (!susp && pw < POLL)
				pw <= pw + 1;
			if (busy && !susp) begin
				left <= left - 1;
				if (left == 1)
					busy <= 1'b0;
			end
			if (!we_q && we_n) begin
				if (busy && !susp && din == SUSP_CODE) begin
					susp <= 1'b1;
				end else if (susp && din == RES_CODE) begin
					susp <= 1'b0;
					if (pw < POLL)
						pw <= 0;
				end else if (armed) begin
					busy  <= 1'b1;
					left  <= PROG_CYC;
					pw    <= 0;
					pdata <= din;
					mem[addr[7:0]] <= din;
					armed <= 1'b0;
				end else begin
					armed <= (din == PROG_CODE);
				end
			end
			if (rd_q && !(ce_n | oe_n)) begin
				if (rh < RH || (busy && !susp && pw < POLL))
					bad <= bad + 8'h01;
				if (busy)
					tog <= ~tog;
			end
		end
	end
endmodule

// ---- pfc_flash_ctrl_bench.sv ----
module pfc_flash_ctrl_bench;
	import pfc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        resetn   = 1'b0;
	logic        hsel     = 1'b0;
	logic        hwrite   = 1'b0;
	logic [1:0]  htrans   = 2'b00;
	logic [31:0] haddr    = '0;
	logic [31:0] hwdata   = '0;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic        hreadyout;
	logic        hresp;
	logic        rst_f_n;
	logic        ce_n;
	logic        oe_n;
	logic        we_n;
	logic        byte_n;
	logic        dq_oe_n;
	logic        rbn;
	logic [20:0] fa;
	logic [15:0] dqo;
	logic [15:0] fdq;
	logic [15:0] dq_wire;
	logic [7:0]  bad;
	int          num_errors = 0;
	int          checked = 0;

	always #20 core_clk = ~core_clk;
	assign dq_wire = !dq_oe_n ? dqo : fdq;

	pfc_flash_ctrl #(.ADDR_W(21)) DUT (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flash_reset_n(rst_f_n),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_byte_n(byte_n),
		.flash_addr(fa), .flash_dq_out(dqo), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_wire),
		.ready_busy_n(rbn));

	pfc_flash_model flash (.core_clk(core_clk), .reset_n(rst_f_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.byte_n(byte_n), .addr(fa), .din(dq_wire), .dq(fdq), .ready_busy_n(rbn), .bad(bad));

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ----
	// Bus access
	// ----
	task automatic hold();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			num_errors++;
			stop_test();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hold();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		hold();
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		ahb(1'b0, a, 32'h0);
	endtask

	// ----
	// Flash operations
	// ----
	task automatic run(input logic [2:0] op, input logic [15:0] d);
		int n;
		wr(OFS_WDATA, {16'h0, d});
		wr(OFS_CMD, {29'h0, op});
		@(posedge core_clk);
		n = 0;
		do begin
			rd(OFS_STATUS);
			n++;
		end while (q[STS_BUSY] !== 1'b0 && n < 600);
		if (n >= 600) begin
			num_errors++;
			stop_test();
		end
	endtask

	task automatic aread(input logic [7:0] a);
		wr(OFS_ADDR, {24'h0, a});
		run(OP_READ, 16'h0);
		rd(OFS_RDATA);
	endtask

	task automatic prog(input logic [7:0] a, input logic [15:0] d);
		wr(OFS_ADDR, {24'h0, a});
		run(OP_WRITE, 16'h00a0);
		run(OP_PROG, d);
		chk({31'h0, rbn}, 32'h0);
	endtask

	task automatic poll_chk(input logic [7:0] a, input logic [15:0] d);
		run(OP_POLL, 16'h0);
		rd(OFS_STATUS);
		chk({31'h0, q[STS_POLL_OK]}, 32'h1);
		chk({31'h0, rbn}, 32'h1);
		// Last poll read may predate ready, so read the array again
		aread(a);
		chk({16'h0, q[15:0]}, {16'h0, d});
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		chk({26'h0, rst_f_n, ce_n, oe_n, we_n, byte_n, dq_oe_n}, 32'h3f);
		chk({30'h0, hresp, hreadyout}, 32'h1);
		rd(OFS_CMD);
		chk(q, 32'h7);
		rd(OFS_CTRL);
		chk(q, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40);
		chk(q, 32'h0);
		wr(OFS_ADDR, 32'h0001_2345);
		rd(OFS_ADDR);
		chk(q, 32'h0001_2345);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			aread(8'(i * 3));
			chk({16'h0, q[15:0]}, {16'h0, 16'ha500 ^ 16'(i * 3)});
		end
		$display("test read done");
		prog(8'h05, 16'h1234);
		poll_chk(8'h05, 16'h1234);
		aread(8'h05);
		chk({16'h0, q[15:0]}, 32'h1234);
		$display("test program done");
		prog(8'h06, 16'h5678);
		run(OP_SUSPEND, 16'h00b0);
		rd(OFS_STATUS);
		chk({30'h0, q[STS_REWAIT], q[STS_SUSP]}, 32'h3);
		aread(8'h03);
		chk({16'h0, q[15:0]}, 32'ha503);
		run(OP_RESUME, 16'h0030);
		poll_chk(8'h06, 16'h5678);
		$display("test early suspend done");
		prog(8'h07, 16'h9abc);
		repeat (POLL_CYC + 20) @(posedge core_clk);
		run(OP_SUSPEND, 16'h00b0);
		rd(OFS_STATUS);
		chk({30'h0, q[STS_WAITED], q[STS_REWAIT]}, 32'h2);
		run(OP_RESUME, 16'h0030);
		poll_chk(8'h07, 16'h9abc);
		$display("test late suspend done");
		prog(8'h08, 16'h0f0f);
		run(OP_RESET, 16'h0);
		chk({31'h0, rbn}, 32'h1);
		aread(8'h03);
		chk({16'h0, q[15:0]}, 32'ha503);
		$display("test hard reset done");
		wr(OFS_CTRL, 32'h1);
		@(posedge core_clk);
		chk({31'h0, byte_n}, 32'h0);
		rd(OFS_CTRL);
		chk(q, 32'h1);
		aread(8'h03);
		chk({24'h0, q[7:0]}, 32'h03);
		wr(OFS_CTRL, 32'h0);
		@(posedge core_clk);
		chk({31'h0, byte_n}, 32'h1);
		$display("test byte mode done");
		chk({24'h0, bad}, 32'h0);
		stop_test();
	end
endmodule
